// File: design/tss_defs.svh
// Constants for the PCM time/space switch: offsets, bit positions, reset values, timing counts.
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH

// -------------------------------------------------------------------------
// Frame structure
// -------------------------------------------------------------------------
`define TSS_LINE_COUNT 8
`define TSS_SLOTS_PER_LINE 32
`define TSS_STORE_DEPTH 256
`define TSS_BIT_LAST 3'h7

// -------------------------------------------------------------------------
// Processor port decode and register fields
// -------------------------------------------------------------------------
`define TSS_SEL_DIRECT 1'b0
`define TSS_SEL_INDIRECT 1'b1
`define TSS_MODE_TE_BIT 0
`define TSS_MODE_ABORT_BIT 1
`define TSS_STAT_Z_BIT 5
`define TSS_CFG_CPS_BIT 0
`define TSS_CFG_RESET 8'hff
`define TSS_CFG_ADDR 8'hfe
`define TSS_CTRL_K_HI_BIT 5
`define TSS_CTRL_K_LO_BIT 4
`define TSS_CTRL_C_LO_BIT 0
`define TSS_CTRL_READ_ONES 8'hcc
`define TSS_CM_RESET 10'h200
`define TSS_IAR_LAST 2'h2

// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
`define TSS_CLK_PERIOD_NS 10
`define TSS_ACCESS_NS 900
`define TSS_ACCESS_CYCLES (`TSS_ACCESS_NS / `TSS_CLK_PERIOD_NS)
`define TSS_PH_LAST_FAST 2'h3
`define TSS_PH_LAST_SLOW 2'h1
`define TSS_SAMPLE_PH_FAST 2'h3
`define TSS_SAMPLE_PH_SLOW 2'h1
`define TSS_OUT_PH_FAST 2'h2
`define TSS_OUT_PH_SLOW 2'h1

`endif

// File: design/tss_pkg.sv
// Types shared by the PCM time/space switch modules.
package tss_pkg;

  // -----------------------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------------------
  // Processor port pins, sampled synchronously.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic sel;
    logic [7:0] data;
  } cpu_bus_in_type;

  // Device clock edges seen in the system clock domain.
  typedef struct packed {
    logic rise;
    logic fall;
  } dev_edge_type;

  // Per-cycle strobes of one bit timer.
  typedef struct packed {
    logic bit_start;
    logic sample;
    logic realign;
  } bit_timing_type;

  // One connection store entry.
  typedef struct packed {
    logic float_bit;
    logic [8:0] src_addr;
  } cm_entry_type;

  // Indirect access sequencer states.
  typedef enum logic [2:0] {
    ia_idle = 3'b001,
    ia_collect = 3'b010,
    ia_settle = 3'b100
  } ia_state_type;

endpackage

// File: design/bit_phase_timer.sv
// Bit phase timer that places bit starts and sample points within each PCM bit.
`timescale 1ns/1ns
`include "tss_defs.svh"

module bit_phase_timer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire tss_pkg::dev_edge_type edges,
  input wire logic fast,
  input wire logic realign,
  input wire logic [1:0] realign_phase,
  output tss_pkg::bit_timing_type timing
);
  import tss_pkg::*;

  // -------------------------------------------------------------------------
  // Phase counter
  // -------------------------------------------------------------------------
  logic [1:0] ph_reg; // Device clock cycle index inside the bit.
  logic [1:0] ph_next;
  logic [1:0] ph_now; // Index that the current rising edge opens.
  logic [1:0] ph_last; // Last index for the chosen clock rate.

  // The next phase wraps every four fast cycles or two slow ones.
  always_comb
  begin
    ph_last = fast ? `TSS_PH_LAST_FAST : `TSS_PH_LAST_SLOW;
    if (realign)
      ph_now = realign_phase;
    else if (ph_reg == ph_last)
      ph_now = 2'h0;
    else
      ph_now = ph_reg + 2'h1;
    ph_next = edges.rise ? ph_now : ph_reg;
    timing.bit_start = edges.rise && (ph_now == 2'h0);
    timing.realign = edges.rise && realign;
    if (fast)
      timing.sample = edges.rise && (ph_now == `TSS_SAMPLE_PH_FAST);
    else
      timing.sample = edges.fall && (ph_reg == `TSS_SAMPLE_PH_SLOW);
  end

  // Registers the phase.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      ph_reg <= 2'h0;
    else
      ph_reg <= ph_next;
  end

endmodule

// File: design/pcm_time_space_switch.sv
// PCM time/space switch core: speech store, connection store and processor port.
`timescale 1ns/1ns
`include "tss_defs.svh"

module pcm_time_space_switch (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic device_clock,
  input wire logic frame_sync_pulse,
  input wire logic primary_access,
  input wire logic [7:0] pcm_serial_inputs,
  input wire tss_pkg::cpu_bus_in_type cpu_in,
  output logic [7:0] pcm_serial_outputs,
  output logic [7:0] pcm_output_enable,
  output logic [7:0] cpu_data_bus_out,
  output logic cpu_data_bus_oe
);
  import tss_pkg::*;

  localparam int ACCESS_MAX = `TSS_ACCESS_CYCLES;

  // -------------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------------
  logic dclk_reg, dclk_next; // Device clock one cycle ago.
  logic sp_reg, sp_next; // Sync level at the last device rising edge.
  dev_edge_type edges; // Device clock edges.
  logic sp_rise, sp_fall; // Sync edges found at a device rising edge.
  logic fast; // High for an 8192 kHz device clock.
  bit_timing_type in_t, out_t; // Strobes of the two bit timers.
  logic out_realign; // Output counter alignment event.
  logic [1:0] out_phase; // Phase forced at output alignment.
  logic [7:0] in_pos_reg, in_pos_next; // Input {slot, bit}.
  logic [7:0] out_pos_reg, out_pos_next; // Output {slot, bit}.
  logic out_load; // Output slot boundary.
  logic byte_done; // Last bit of an input slot sampled.
  logic [7:0] wbuf_all [8]; // Finished input bytes per line.
  logic [7:0] store_reg [256], store_next [256]; // Speech store.
  logic acc_reg, acc_next; // Store access phase: 0 write, 1 read.
  logic [7:0] pend_reg, pend_next; // Lines with a byte still to write.
  logic [4:0] wslot_reg, wslot_next; // Slot of the pending bytes.
  logic [3:0] fetch_idx_reg, fetch_idx_next; // Line being fetched, 8 idle.
  logic [4:0] fetch_slot_reg, fetch_slot_next; // Slot being fetched.
  logic [7:0] pre_byte_reg [8], pre_byte_next [8]; // Bytes for next slot.
  logic [7:0] pre_float_reg, pre_float_next; // Float flags for next slot.
  logic sm_write, sm_read; // Store access in this cycle.
  logic found; // A pending line was chosen.
  cm_entry_type entry; // Entry under fetch.
  cpu_bus_in_type req_reg, req_next; // Port pins one cycle ago.
  logic wr_end, rd_end, rd_start; // Selected strobe edges.
  ia_state_type state_reg, state_next; // Indirect access sequencer.
  logic [7:0] iar_reg [3], iar_next [3]; // Control, data, address bytes.
  logic [1:0] idx_reg, idx_next; // Next byte of the three.
  logic [6:0] timer_reg, timer_next; // Settling countdown.
  logic te_reg, te_next; // Tristate scheme select.
  logic [7:0] cfg_reg, cfg_next; // Clock configuration register.
  cm_entry_type cm_reg [256], cm_next [256]; // Connection store.
  logic [7:0] dout_reg, dout_next; // Read data.
  logic doe_reg, doe_next; // Read data drive enable.
  logic [7:0] status_val; // Condition register value.
  logic go, cm_wr_go, cfg_rd_go; // Access started this cycle.
  logic [7:0] ctrl, addr; // Fields of the access being started.

  // -------------------------------------------------------------------------
  // Device clock and sync edges
  // -------------------------------------------------------------------------
  // Edges are found by comparing with last cycle; the pins are synchronous.
  always_comb
  begin
    dclk_next = device_clock;
    edges.rise = device_clock && !dclk_reg;
    edges.fall = !device_clock && dclk_reg;
    sp_next = edges.rise ? frame_sync_pulse : sp_reg;
    sp_rise = edges.rise && frame_sync_pulse && !sp_reg;
    sp_fall = edges.rise && !frame_sync_pulse && sp_reg;
    fast = cfg_reg[`TSS_CFG_CPS_BIT];
    out_realign = primary_access ? sp_rise : sp_fall;
    // slot 0 two fast periods early
    if (primary_access)
      out_phase = 2'h0;
    else
      out_phase = fast ? `TSS_OUT_PH_FAST : `TSS_OUT_PH_SLOW;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dclk_reg <= 1'b0;
      sp_reg <= 1'b0;
    end
    else
    begin
      dclk_reg <= dclk_next;
      sp_reg <= sp_next;
    end
  end

  bit_phase_timer in_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .edges(edges),
    .fast(fast),
    .realign(sp_rise),
    .realign_phase(2'h0),
    .timing(in_t)
  );

  bit_phase_timer out_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .edges(edges),
    .fast(fast),
    .realign(out_realign),
    .realign_phase(out_phase),
    .timing(out_t)
  );

  // -------------------------------------------------------------------------
  // Frame counters
  // -------------------------------------------------------------------------
  // Each counter holds 32 slots of 8 bits and wraps once a frame.
  always_comb
  begin
    in_pos_next = in_pos_reg;
    if (in_t.realign)
      in_pos_next = 8'h00;
    else if (in_t.bit_start)
      in_pos_next = in_pos_reg + 8'h01;
    out_pos_next = out_pos_reg;
    if (out_t.realign)
      out_pos_next = 8'h00;
    else if (out_t.bit_start)
      out_pos_next = out_pos_reg + 8'h01;
    out_load = out_t.bit_start && (out_pos_next[2:0] == 3'h0);
    byte_done = in_t.sample && (in_pos_reg[2:0] == `TSS_BIT_LAST);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_pos_reg <= 8'h00;
      out_pos_reg <= 8'h00;
    end
    else
    begin
      in_pos_reg <= in_pos_next;
      out_pos_reg <= out_pos_next;
    end
  end

  // -------------------------------------------------------------------------
  // Per-line deserializer and serializer
  // -------------------------------------------------------------------------
  for (genvar g = 0; g < `TSS_LINE_COUNT; g++)
  begin : line_gen
    logic [7:0] shift_reg, shift_next; // Bits of the slot in progress.
    logic [7:0] wbuf_reg, wbuf_next; // Finished byte awaiting the store.
    logic [7:0] cur_reg, cur_next; // Byte being sent.
    logic data_reg, data_next; // Line level.
    logic en_reg, en_next; // Line drive enable.

    // Shifts in MSB first and sends MSB first.
    always_comb
    begin
      shift_next = shift_reg;
      wbuf_next = wbuf_reg;
      cur_next = cur_reg;
      data_next = data_reg;
      en_next = en_reg;
      if (in_t.sample)
      begin
        shift_next = {shift_reg[6:0], pcm_serial_inputs[g]};
        if (in_pos_reg[2:0] == `TSS_BIT_LAST)
          wbuf_next = shift_next;
      end
      if (out_t.bit_start)
      begin
        if (out_load)
        begin
          cur_next = pre_byte_reg[g];
          en_next = !pre_float_reg[g];
        end
        data_next = cur_next[3'h7 - out_pos_next[2:0]];
      end
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        shift_reg <= 8'h00;
        wbuf_reg <= 8'h00;
        cur_reg <= 8'h00;
        data_reg <= 1'b0;
        en_reg <= 1'b0;
      end
      else
      begin
        shift_reg <= shift_next;
        wbuf_reg <= wbuf_next;
        cur_reg <= cur_next;
        data_reg <= data_next;
        en_reg <= en_next;
      end
    end

    assign wbuf_all[g] = wbuf_reg;
    assign pcm_serial_outputs[g] = data_reg;
    assign pcm_output_enable[g] = en_reg;
  end

  // -------------------------------------------------------------------------
  // Speech store and fetch
  // -------------------------------------------------------------------------
  // Even cycles drain one finished byte, odd cycles fetch one output byte.
  // Eight of each fit easily in one bit period, so nothing ever waits long.
  always_comb
  begin
    acc_next = !acc_reg;
    store_next = store_reg;
    pend_next = pend_reg;
    wslot_next = wslot_reg;
    fetch_idx_next = fetch_idx_reg;
    fetch_slot_next = fetch_slot_reg;
    pre_byte_next = pre_byte_reg;
    pre_float_next = pre_float_reg;
    found = 1'b0;
    sm_read = 1'b0;
    entry = cm_reg[{fetch_idx_reg[2:0], fetch_slot_reg}];
    if (!acc_reg)
    begin
      for (int i = 0; i < `TSS_LINE_COUNT; i++)
      begin
        if (pend_reg[i] && !found)
        begin
          found = 1'b1;
          store_next[{3'(i), wslot_reg}] = wbuf_all[i];
          pend_next[i] = 1'b0;
        end
      end
    end
    else if (!fetch_idx_reg[3])
    begin
      sm_read = 1'b1;
      // store address from entry; the ninth bit lies beyond the store
      pre_byte_next[fetch_idx_reg[2:0]] = store_reg[entry.src_addr[7:0]];
      if (te_reg)
        pre_float_next[fetch_idx_reg[2:0]] = (entry.src_addr == 9'h000);
      else
        pre_float_next[fetch_idx_reg[2:0]] = entry.float_bit;
      fetch_idx_next = fetch_idx_reg + 4'h1;
    end
    sm_write = found;
    // A new slot starts: gather the bytes of the one after it.
    if (out_load)
    begin
      fetch_idx_next = 4'h0;
      fetch_slot_next = out_pos_next[7:3] + 5'h01;
    end
    // A fresh byte on every line wins over the drain of this cycle.
    if (byte_done)
    begin
      pend_next = 8'hff;
      wslot_next = in_pos_reg[7:3];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      store_reg <= '{default: 8'h00};
      acc_reg <= 1'b0;
      pend_reg <= 8'h00;
      wslot_reg <= 5'h00;
      fetch_idx_reg <= 4'h8;
      fetch_slot_reg <= 5'h00;
      pre_byte_reg <= '{default: 8'h00};
      pre_float_reg <= 8'hff;
    end
    else
    begin
      store_reg <= store_next;
      acc_reg <= acc_next;
      pend_reg <= pend_next;
      wslot_reg <= wslot_next;
      fetch_idx_reg <= fetch_idx_next;
      fetch_slot_reg <= fetch_slot_next;
      pre_byte_reg <= pre_byte_next;
      pre_float_reg <= pre_float_next;
    end
  end

  // -------------------------------------------------------------------------
  // Processor port and indirect access
  // -------------------------------------------------------------------------
  // Strobe edges count only if chip select was low in the last cycle with the strobe low.
  // Write data is the bus level of the last cycle with the strobe low.
  always_comb
  begin
    req_next = cpu_in;
    wr_end = !req_reg.cs_n && !req_reg.wr_n && cpu_in.wr_n;
    rd_end = !req_reg.cs_n && !req_reg.rd_n && cpu_in.rd_n;
    doe_next = !cpu_in.cs_n && !cpu_in.rd_n;
    rd_start = doe_next && !doe_reg;
    state_next = state_reg;
    iar_next = iar_reg;
    idx_next = idx_reg;
    timer_next = timer_reg;
    te_next = te_reg;
    cfg_next = cfg_reg;
    cm_next = cm_reg;
    go = 1'b0;
    cm_wr_go = 1'b0;
    cfg_rd_go = 1'b0;
    status_val = 8'h00;
    status_val[`TSS_STAT_Z_BIT] = (state_reg != ia_idle);
    if (wr_end && (req_reg.sel == `TSS_SEL_DIRECT))
    begin
      te_next = req_reg.data[`TSS_MODE_TE_BIT];
      if (req_reg.data[`TSS_MODE_ABORT_BIT])
      begin
        state_next = ia_idle;
        idx_next = 2'h0;
      end
    end
    // only path to config and store
    else if ((wr_end || rd_end) && req_reg.sel && (state_reg != ia_settle))
    begin
      if (wr_end)
        iar_next[idx_reg] = req_reg.data;
      if (idx_reg == `TSS_IAR_LAST)
      begin
        state_next = ia_settle;
        idx_next = 2'h0;
        timer_next = 7'(ACCESS_MAX - 1);
        go = wr_end;
      end
      else
      begin
        state_next = ia_collect;
        idx_next = idx_reg + 2'h1;
      end
    end
    else if (state_reg == ia_settle)
    begin
      if (timer_reg == 7'h00)
        state_next = ia_idle;
      else
        timer_next = timer_reg - 7'h01;
    end
    ctrl = iar_next[0];
    addr = iar_next[2];
    if (go)
    begin
      if (ctrl[`TSS_CTRL_K_HI_BIT] && ctrl[`TSS_CTRL_K_LO_BIT])
      begin
        if (addr == `TSS_CFG_ADDR)
        begin
          if (ctrl[`TSS_CTRL_C_LO_BIT])
          begin
            cfg_rd_go = 1'b1;
            iar_next[1] = cfg_reg;
            iar_next[0][1:0] = 2'h3;
          end
          else
            cfg_next = iar_next[1];
        end
      end
      else if (!ctrl[`TSS_CTRL_K_HI_BIT] && !ctrl[`TSS_CTRL_K_LO_BIT])
      begin
        {iar_next[0][1:0], iar_next[1]} = cm_reg[addr];
      end
      else
      begin
        cm_wr_go = 1'b1;
        cm_next[addr] = cm_entry_type'({ctrl[1:0], iar_next[1]});
      end
    end
    dout_next = dout_reg;
    if (rd_start)
    begin
      if (cpu_in.sel == `TSS_SEL_DIRECT)
        dout_next = status_val;
      else if (idx_reg == 2'h0)
        dout_next = iar_reg[0] | `TSS_CTRL_READ_ONES;
      else
        dout_next = iar_reg[idx_reg];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 1'b0, data: 8'h00};
      state_reg <= ia_idle;
      iar_reg <= '{default: 8'h00};
      idx_reg <= 2'h0;
      timer_reg <= 7'h00;
      te_reg <= 1'b0;
      cfg_reg <= `TSS_CFG_RESET;
      cm_reg <= '{default: `TSS_CM_RESET};
      dout_reg <= 8'h00;
      doe_reg <= 1'b0;
    end
    else
    begin
      req_reg <= req_next;
      state_reg <= state_next;
      iar_reg <= iar_next;
      idx_reg <= idx_next;
      timer_reg <= timer_next;
      te_reg <= te_next;
      cfg_reg <= cfg_next;
      cm_reg <= cm_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  assign cpu_data_bus_out = dout_reg;
  assign cpu_data_bus_oe = doe_reg;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  a_first_transfer: assert property ((state_reg == ia_idle) && wr_end && req_reg.sel
    |=> status_val[`TSS_STAT_Z_BIT]) else $error("busy flag not set");
  a_settle_bound: assert property ($rose(state_reg == ia_settle)
    |-> ##[1:ACCESS_MAX] (state_reg != ia_settle)) else $error("access too slow");
  a_cm_write: assert property (cm_wr_go |=> cm_reg[$past(addr)] == cm_entry_type'(
    {$past(ctrl[1:0]), $past(iar_next[1])})) else $error("entry not written");
  a_cfg_read: assert property (cfg_rd_go |=> (iar_reg[0][1:0] == 2'h3)
    && (iar_reg[1] == $past(cfg_reg))) else $error("config read wrong");
  a_zero_float: assert property (sm_read && te_reg && (entry.src_addr == 9'h000)
    |=> pre_float_reg[$past(fetch_idx_reg[2:0])]) else $error("zero address drives");
  a_valid_float: assert property (sm_read && !te_reg |=> pre_float_reg[$past(
    fetch_idx_reg[2:0])] == $past(entry.float_bit)) else $error("validity lost");
  a_load_enable: assert property (out_load |=> pcm_output_enable == ~$past(pre_float_reg))
    else $error("enable not loaded");
  a_alternate: assert property (sm_write |-> !acc_reg ##1 !sm_write)
    else $error("store writes not alternating");
  a_read_drive: assert property (rd_start && !cpu_in.sel |=> cpu_data_bus_oe
    && (cpu_data_bus_out == $past(status_val))) else $error("status not driven");
  a_cs_gate: assert property (cpu_in.cs_n |=> !cpu_data_bus_oe)
    else $error("bus driven unselected");
  a_in_align: assert property (in_t.realign |=> (in_pos_reg == 8'h00))
    else $error("input counter not aligned");
  a_out_step: assert property (out_t.bit_start && !out_t.realign
    |=> out_pos_reg == $past(out_pos_reg) + 8'h01) else $error("output count skipped");

  c_cm_write: cover property (cm_wr_go);
  c_cfg_read: cover property (cfg_rd_go);
  c_abort: cover property ((state_reg == ia_collect) ##1 (state_reg == ia_idle));
  c_float_load: cover property (out_load && (pre_float_reg != 8'h00));

endmodule

// File: dv/pcm_line_model.sv
// Model of the PCM line partner: device clock, frame sync and input lines.
`timescale 1ns/1ns
module pcm_line_model (
  input wire logic sys_clk,
  input wire logic nrst,
  output logic device_clock,
  output logic frame_sync_pulse,
  output logic [7:0] pcm_serial_inputs
);
  // Divider and count of device clock rising edges within a frame.
  logic [2:0] div_reg;
  logic [11:0] tick_reg;

  // The clock toggles every six system cycles, close to the fast rate.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_reg <= 3'h0;
      device_clock <= 1'b0;
      tick_reg <= 12'h000;
    end
    else if (div_reg == 3'h5)
    begin
      div_reg <= 3'h0;
      device_clock <= !device_clock;
      if (!device_clock)
        tick_reg <= tick_reg + 12'h001;
    end
    else
      div_reg <= div_reg + 3'h1;
  end

  // frame of 1024 clocks, sync high for two.
  assign frame_sync_pulse = (tick_reg[9:1] == 9'h000);
  // Lines change at bit starts only, so every sample point sees settled data.
  assign pcm_serial_inputs = tick_reg[9:2] ^ 8'ha5;
endmodule

// File: dv/pcm_time_space_switch_tb.sv
// Self-checking testbench for the PCM time/space switch processor port.
`timescale 1ns/1ns
`define check(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module pcm_time_space_switch_tb;
  import tss_pkg::*;
  logic sys_clk, nrst, device_clock, frame_sync_pulse;
  logic [7:0] pcm_serial_inputs, pcm_serial_outputs, pcm_output_enable, cpu_data_bus_out;
  logic cpu_data_bus_oe;
  cpu_bus_in_type cpu_in;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h6257;
  logic [7:0] rd_val, a;
  logic [23:0] got;
  logic [9:0] e;

  pcm_line_model line (.sys_clk(sys_clk), .nrst(nrst), .device_clock(device_clock),
    .frame_sync_pulse(frame_sync_pulse), .pcm_serial_inputs(pcm_serial_inputs));
  pcm_time_space_switch dut (.sys_clk(sys_clk), .nrst(nrst), .device_clock(device_clock),
    .frame_sync_pulse(frame_sync_pulse), .primary_access(1'b0),
    .pcm_serial_inputs(pcm_serial_inputs), .cpu_in(cpu_in),
    .pcm_serial_outputs(pcm_serial_outputs), .pcm_output_enable(pcm_output_enable),
    .cpu_data_bus_out(cpu_data_bus_out), .cpu_data_bus_oe(cpu_data_bus_oe));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end

  // Xorshift step; the seed is fixed so every run is the same.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected read-back of a connection entry: unused control bits read as ones.
  function automatic logic [23:0] exp_cm(input logic [9:0] v, input logic [7:0] ad);
    return {8'hcc | {6'h00, v[9:8]}, v[7:0], ad};
  endfunction

  // Level that an input line carries in a given bit of the frame.
  function automatic logic in_bit(input logic [7:0] k, input logic [2:0] g);
    logic [7:0] v;
    v = k ^ 8'ha5;
    return v[g];
  endfunction

  // One strobe of three cycles, then two idle cycles so strobes stay separated.
  task automatic xfer(input logic w, input logic sl, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_in <= '{1'b0, w, !w, sl, d};
    repeat (2) @(posedge sys_clk);
    #1 rd_val = cpu_data_bus_out;
    if (!w) `check(cpu_data_bus_oe, 1'b1)
    @(posedge sys_clk);
    cpu_in <= '{1'b1, 1'b1, 1'b1, sl, d};
    repeat (2) @(posedge sys_clk);
  endtask

  // Three indirect transfers, then the busy flag must stand and later clear.
  task automatic seq(input logic w, input logic [23:0] b);
    for (int i = 0; i < 3; i++)
    begin
      xfer(w, 1'b1, b[23-8*i -: 8]);
      got[23-8*i -: 8] = rd_val;
    end
    xfer(1'b0, 1'b0, 8'h00);
    `check(rd_val[5], 1'b1)
    repeat (90) @(posedge sys_clk);
    xfer(1'b0, 1'b0, 8'h00);
    `check(rd_val, 8'h00)
  endtask

  task automatic report_and_stop;
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // A hang is cut short well past the expected run length.
  initial
  begin
    repeat (50000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    nrst = 1'b0;
    cpu_in = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    `check({cpu_data_bus_oe, pcm_output_enable}, 9'h000)
    xfer(1'b1, 1'b0, 8'h00);
    // Strobe without chip select must leave the indirect port untouched.
    cpu_in <= '{1'b1, 1'b1, 1'b0, 1'b1, 8'h31};
    repeat (3) @(posedge sys_clk);
    cpu_in <= '{1'b1, 1'b1, 1'b1, 1'b1, 8'h31};
    xfer(1'b0, 1'b0, 8'h00);
    `check(rd_val, 8'h00)
    seq(1'b1, 24'h3100fe);
    seq(1'b0, 24'h000000);
    `check(got, 24'hfffffe)
    // Both write codes of the target bits; address fe must still reach the store.
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      e = seed[9:0];
      a = (i == 0) ? 8'hfe : seed[23:16];
      seq(1'b1, {2'b00, (i[0] ? 2'b10 : 2'b01), 2'b00, e[9:8], e[7:0], a});
      seq(1'b1, {16'h0000, a});
      seq(1'b0, 24'h000000);
      `check(got, exp_cm(e, a))
    end
    // Line 1 slot 3 switched to line 0 slot 10 must appear bit by bit.
    seq(1'b1, 24'h10230a);
    @(posedge frame_sync_pulse);
    for (int b = 0; b < 8; b++)
    begin
      do @(posedge sys_clk); while (line.tick_reg[9:0] != 10'(4 * (80 + b) + 2));
      #1 `check(pcm_output_enable[0], 1'b1)
      `check(pcm_serial_outputs[0], in_bit(8'(24 + b), 3'h1))
    end
    // Scheme 1: an all-zero source address floats the channel.
    xfer(1'b1, 1'b0, 8'h01);
    seq(1'b1, 24'h10000a);
    @(posedge frame_sync_pulse);
    do @(posedge sys_clk); while (line.tick_reg[9:0] != 10'h142);
    #1 `check(pcm_output_enable[0], 1'b0)
    report_and_stop();
  end
endmodule
